// File: verilog/ers_consts.vh
`ifndef ERS_CONSTS_VH
`define ERS_CONSTS_VH
`define ERS_STATUS_BASE      12'h010
`define ERS_RECORD_STRIDE    12'h040
`define ERS_FEATURE_OFFSET   12'h800
`define ERS_CONTROL_OFFSET   12'h808
`define ERS_INJ_CTL_OFFSET   12'h810
`define ERS_ADDR_W           12
`define ERS_NUM_RECORDS      2
`define ERS_BIT_AV           31
`define ERS_BIT_V            30
`define ERS_BIT_UE           29
`define ERS_BIT_ER           28
`define ERS_BIT_OF           27
`define ERS_BIT_DE           23
`define ERS_GEN_LATENT       4
`define ERS_GEN_SIGNALED     3
`define ERS_GEN_UNRECOV      2
`define ERS_GEN_UNCONTAIN    1
`define ERS_GEN_OVERFLOW     0
`define ERS_GEN_MASK         64'h0000_0000_0000_001F
`define ERS_STATUS_RW_MASK   64'h0000_0000_F880_0000
`endif

// File: verilog/ers_feature.v
`timescale 1ns/1ps
`default_nettype none
`include "ers_consts.vh"
// Injection capability bits; error-type bits 4:1 gated by node support when the extended flag is set
module ers_feature (
  input  wire [4:0]  gen_impl,
  input  wire        extended_feature_flag,
  input  wire [4:0]  node_support,
  output wire [63:0] injection_feature_reg
);
  wire [4:0] support;
  // Without extended flag, only implementation gates the bit
  assign support = extended_feature_flag ? node_support : 5'h1F;
  // Overflow control has no error-type gating
  assign injection_feature_reg = {59'h0, gen_impl[4:1] & support[4:1],
                                  gen_impl[0]};
endmodule
`default_nettype wire

// File: verilog/ers_record.v
`timescale 1ns/1ps
`default_nettype none
`include "ers_consts.vh"
// One status record: V, AV, UE, ER, OF, DE
module ers_record (
  input  wire        ref_clk,
  input  wire        reset,
  input  wire        rec_event,
  input  wire        ev_addr,
  input  wire        ev_uncorr,
  input  wire        ev_deferred,
  input  wire        ev_abort,
  input  wire        inj_active,
  input  wire        inj_of_ovr,
  input  wire        inj_of_val,
  input  wire        clr_wr,
  input  wire [63:0] clr_data,
  output wire [63:0] status
);
  reg av;
  reg v;
  reg ue;
  reg er;
  reg of_bit;
  reg de;
  wire of_hw;
  wire c_av;
  wire c_v;
  wire c_ue;
  wire c_er;
  wire c_of;
  wire c_de;
  assign c_av = clr_wr & clr_data[`ERS_BIT_AV];
  assign c_v  = clr_wr & clr_data[`ERS_BIT_V];
  assign c_ue = clr_wr & clr_data[`ERS_BIT_UE];
  assign c_er = clr_wr & clr_data[`ERS_BIT_ER];
  assign c_of = clr_wr & clr_data[`ERS_BIT_OF];
  assign c_de = clr_wr & clr_data[`ERS_BIT_DE];
  // Overflow when a non-corrected error lands on a valid record
  assign of_hw = v & (ev_uncorr | ev_deferred);
  // Cold reset only; error recovery reset never reaches here
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      av     <= 1'b0;
      v      <= 1'b0;
      ue     <= 1'b0;
      er     <= 1'b0;
      of_bit <= 1'b0;
      de     <= 1'b0;
    end else begin
      // Hardware set wins over a same-cycle clear
      av <= (rec_event & ev_addr) | (av & ~c_av);
      v  <= rec_event | (v & ~c_v);
      ue <= (rec_event & ev_uncorr) | (ue & ~c_ue);
      de <= (rec_event & ev_deferred) | (de & ~c_de);
      er <= (rec_event & ev_abort & (ev_uncorr | ev_deferred))
            | (er & ~c_er);
      if (rec_event & inj_active & inj_of_ovr) begin
        of_bit <= inj_of_val;
      end else begin
        of_bit <= (rec_event & of_hw) | (of_bit & ~c_of);
      end
    end
  end
  // UE, ER, OF and DE read as zero while invalid; AV reads as stored
  assign status = {32'h0, av, v, ue & v, er & v & (ue | de), of_bit & v,
                   3'h0, de & v, 23'h0};
endmodule
`default_nettype wire

// File: verilog/ers_bank.v
// Behaviour
// - Latent/restartable capability reads 1 only when injectable; else control bit reads zero.
// - Latent/restartable capability sits at feature register bit four.
// - Capability bit three reports signaled/recoverable injection; gates its control bit.
// - Capability bit two reports unrecoverable injection; gates its control bit.
// - Capability bit one reports uncontainable injection; gates its control bit.
// - With extended feature flag set, unsupported error types read zero capability.
// - Capability bit zero lets injected errors load overflow from control bit.
// - Status is 64-bit read/write at base plus 64 bytes per record.
// - Selected system view reads record chosen by select; 32-bit view low half.
// - Unimplemented record status reads zero.
// - Feature info comes from first record of the owning node.
// - Writing zero to implementation fields quiesces record and drops interrupt; here zero to 0x808 bit 0 only drops the interrupt, records still log.
// - Interrupting syndrome fields are off at cold reset until enabled.
// - Status bits 63:32 and 18:16 read zero, writes ignored.
// - Address valid is write-one-clear, zero on cold reset.
// - Record valid sets on any recorded error; write-one-clear; zero on reset.
// - Uncorrected sets for non-corrected non-deferred errors; reads zero when invalid.
// - Error-reported sets when an in-band abort went to the requester.
// - Abort on deferred errors is allowed here; reset to zero.
// - Error-reported reads zero if invalid or both deferred and uncorrected clear.
`timescale 1ns/1ps
`default_nettype none
`include "ers_consts.vh"
module ers_bank (
  input  wire                      ref_clk,
  input  wire                      reset,
  input  wire                      reg_wr,
  input  wire                      reg_rd,
  input  wire [`ERS_ADDR_W-1:0]    reg_addr,
  input  wire [63:0]               reg_wdata,
  output reg  [63:0]               reg_rdata,
  input  wire [0:0]                record_index_select,
  input  wire                      sys_wr,
  input  wire [63:0]               sys_wdata,
  output reg  [31:0]               selected_status_32,
  output reg  [63:0]               selected_status_64,
  input  wire [`ERS_NUM_RECORDS-1:0] err_event,
  input  wire                      err_addr,
  input  wire                      err_uncorr,
  input  wire                      err_deferred,
  input  wire                      write_abort_enable,
  input  wire                      read_abort_enable,
  input  wire                      err_is_write,
  input  wire                      extended_feature_flag,
  input  wire [4:0]                node_support,
  input  wire [4:0]                gen_impl,
  input  wire                      inj_active,
  output reg  [63:0]               injection_control_reg,
  output wire                      fault_irq
);
  // ****************************************
  // Decode
  // ****************************************
  function is_status;
    input [`ERS_ADDR_W-1:0] a;
    input integer           idx;
    begin
      is_status = (a == (`ERS_STATUS_BASE + idx[11:0] * `ERS_RECORD_STRIDE));
    end
  endfunction

  wire [63:0] status [0:`ERS_NUM_RECORDS-1];
  wire [63:0] injection_feature_reg;
  wire        abort;
  reg         irq_enable;

  // Abort goes back only when the matching enable is set
  assign abort = err_is_write ? write_abort_enable : read_abort_enable;

  // Both records share one node, so record 0 supplies the features
  ers_feature u_feat (
    .gen_impl              (gen_impl),
    .extended_feature_flag (extended_feature_flag),
    .node_support          (node_support),
    .injection_feature_reg (injection_feature_reg)
  );

  // ****************************************
  // Records
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < `ERS_NUM_RECORDS; g = g + 1) begin : g_rec
      wire        reg_hit;
      wire        sys_hit;
      wire        clr;
      wire [63:0] clr_bits;
      assign reg_hit  = reg_wr & is_status(reg_addr, g);
      assign sys_hit  = sys_wr & (record_index_select == g);
      assign clr      = reg_hit | sys_hit;
      // Both sources merge so a same-cycle bus and system clear both land
      assign clr_bits = ({64{reg_hit}} & reg_wdata) | ({64{sys_hit}} & sys_wdata);
      ers_record u_rec (
        .ref_clk     (ref_clk),
        .reset       (reset),
        .rec_event   (err_event[g]),
        .ev_addr     (err_addr),
        .ev_uncorr   (err_uncorr),
        .ev_deferred (err_deferred),
        .ev_abort    (abort),
        .inj_active  (inj_active),
        .inj_of_ovr  (injection_feature_reg[`ERS_GEN_OVERFLOW]),
        .inj_of_val  (injection_control_reg[`ERS_GEN_OVERFLOW]),
        .clr_wr      (clr),
        .clr_data    (clr_bits),
        .status      (status[g])
      );
    end
  endgenerate

  // ****************************************
  // Control registers
  // ****************************************
  // Interrupts stay off from cold reset until software enables them
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      injection_control_reg <= 64'h0000_0000_0000_0000;
      irq_enable            <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == `ERS_INJ_CTL_OFFSET) begin
        // Unsupported control bits stay zero
        injection_control_reg <= reg_wdata & injection_feature_reg;
      end
      if (reg_addr == `ERS_CONTROL_OFFSET) begin
        irq_enable <= reg_wdata[0];
      end
    end
  end

  // Valid in either record with enable drives the request; clearing valid in both records drops it
  assign fault_irq = irq_enable & (status[0][`ERS_BIT_V] | status[1][`ERS_BIT_V]);

  // ****************************************
  // Read path
  // ****************************************
  integer i;
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      reg_rdata          <= 64'h0000_0000_0000_0000;
      selected_status_32 <= 32'h0000_0000;
      selected_status_64 <= 64'h0000_0000_0000_0000;
    end else begin
      selected_status_64 <= status[record_index_select];
      selected_status_32 <= status[record_index_select][31:0];
      if (reg_rd) begin
        // Unmapped and unimplemented records read zero
        reg_rdata <= 64'h0000_0000_0000_0000;
        for (i = 0; i < `ERS_NUM_RECORDS; i = i + 1) begin
          if (is_status(reg_addr, i)) begin
            reg_rdata <= status[i];
          end
        end
        if (reg_addr == `ERS_FEATURE_OFFSET) begin
          reg_rdata <= injection_feature_reg;
        end
        if (reg_addr == `ERS_INJ_CTL_OFFSET) begin
          reg_rdata <= injection_control_reg;
        end
        if (reg_addr == `ERS_CONTROL_OFFSET) begin
          reg_rdata <= {63'h0, irq_enable};
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: verification/ers_bank_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "ers_consts.vh"
// ****************************************
// Status bank checker
// ****************************************
module ers_bank_chk (
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [11:0] reg_addr,
  input wire logic [63:0] reg_rdata,
  input wire logic [0:0]  record_index_select,
  input wire logic        sys_wr,
  input wire logic [31:0] selected_status_32,
  input wire logic [63:0] selected_status_64,
  input wire logic [1:0]  err_event,
  input wire logic        extended_feature_flag,
  input wire logic [4:0]  node_support,
  input wire logic [4:0]  gen_impl,
  input wire logic [63:0] injection_control_reg
);
  // Error-type capability as the node reports it
  wire [4:1] cap = gen_impl[4:1] & (extended_feature_flag ? node_support[4:1] : 4'hF);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  rsv_zero_a: assert property (reg_rdata[63:32] == 32'h0 && reg_rdata[18:16] == 3'h0)
    else $error("reserved bits not zero");
  low_half_a: assert property (selected_status_32 == selected_status_64[31:0])
    else $error("32-bit view differs");
  valid_set_a: assert property (err_event[0] && !record_index_select
    ##1 !record_index_select |=> selected_status_64[30])
    else $error("valid not set by event");
  ue_needs_v_a: assert property (selected_status_64[29] |-> selected_status_64[30])
    else $error("uncorrected without valid");
  er_needs_a: assert property (selected_status_64[28] |->
    selected_status_64[30] && (selected_status_64[29] || selected_status_64[23]))
    else $error("reported without cause");
  fall_by_wr_a: assert property ($fell(selected_status_64[30]) &&
    $past(record_index_select, 1) == $past(record_index_select, 2) |->
    $past(sys_wr, 2) || $past(reg_wr, 2))
    else $error("valid dropped without write");
  hole_zero_a: assert property (reg_rd && reg_addr == 12'h090 |=> reg_rdata == 64'h0)
    else $error("missing record not zero");
  feat_gate_a: assert property (reg_rd && reg_addr == 12'h800 |=>
    reg_rdata[4:1] == cap && reg_rdata[0] == gen_impl[0] && reg_rdata[63:5] == 59'h0)
    else $error("capability bits wrong");
  ctl_gate_a: assert property ((injection_control_reg[4:1] & ~cap) == 4'h0)
    else $error("control bit not gated");
  cover property (err_event[0]);
  cover property (sys_wr);
  cover property (reg_wr && err_event[1]);
endmodule
bind ers_bank ers_bank_chk u_ers_bank_chk (
  .ref_clk(ref_clk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_rdata(reg_rdata), .record_index_select(record_index_select), .sys_wr(sys_wr),
  .selected_status_32(selected_status_32), .selected_status_64(selected_status_64),
  .err_event(err_event), .extended_feature_flag(extended_feature_flag),
  .node_support(node_support), .gen_impl(gen_impl),
  .injection_control_reg(injection_control_reg)
);
`default_nettype wire

// File: verification/ers_bank_bench.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Status bank bench
// ****************************************
module ers_bank_bench;
  logic ref_clk, reset, reg_wr, reg_rd, sys_wr, err_addr, err_uncorr, err_deferred;
  logic write_abort_enable, read_abort_enable, err_is_write, extended_feature_flag;
  logic inj_active, fault_irq;
  logic [11:0] reg_addr;
  logic [63:0] reg_wdata, sys_wdata, reg_rdata, selected_status_64, injection_control_reg;
  logic [31:0] selected_status_32;
  logic [0:0]  record_index_select;
  logic [1:0]  err_event;
  logic [4:0]  node_support, gen_impl;
  int          error_cnt;
  int          tests_run;
  ers_bank u_ers_bank (
    .ref_clk(ref_clk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .record_index_select(record_index_select), .sys_wr(sys_wr), .sys_wdata(sys_wdata),
    .selected_status_32(selected_status_32), .selected_status_64(selected_status_64),
    .err_event(err_event), .err_addr(err_addr), .err_uncorr(err_uncorr),
    .err_deferred(err_deferred), .write_abort_enable(write_abort_enable),
    .read_abort_enable(read_abort_enable), .err_is_write(err_is_write),
    .extended_feature_flag(extended_feature_flag), .node_support(node_support),
    .gen_impl(gen_impl), .inj_active(inj_active),
    .injection_control_reg(injection_control_reg), .fault_irq(fault_irq)
  );
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [11:0] a, input logic [63:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [63:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  task ev(input logic [1:0] r, input logic a, input logic u, input logic d);
    @(posedge ref_clk);
    err_event <= r; err_addr <= a; err_uncorr <= u; err_deferred <= d;
    @(posedge ref_clk);
    err_event <= 2'b00;
  endtask
  task finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    {reg_wr, reg_rd, sys_wr, err_addr, err_uncorr, err_deferred} = 6'h00;
    {read_abort_enable, inj_active, err_event, record_index_select} = 5'h00;
    write_abort_enable = 1'b1; err_is_write = 1'b1; extended_feature_flag = 1'b1;
    reg_addr = 12'h000; reg_wdata = 64'h0; sys_wdata = 64'h0;
    node_support = 5'h15; gen_impl = 5'h1F;
    error_cnt = 0; tests_run = 0; reset = 1'b1;
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    // Capability gating and masked control writes
    rd(12'h800, 64'h15);
    wr(12'h810, ~64'h0);
    rd(12'h810, 64'h15);
    chk(injection_control_reg, 64'h15);
    // Control cleared first so no stale bit outlives the old capability set
    wr(12'h810, 64'h0);
    @(posedge ref_clk);
    extended_feature_flag <= 1'b0; gen_impl <= 5'h0B;
    rd(12'h800, 64'h0B);
    wr(12'h810, ~64'h0);
    rd(12'h810, 64'h0B);
    // Injected error loads overflow from control, even on an idle record
    inj_active <= 1'b1;
    ev(2'b10, 1'b0, 1'b0, 1'b0);
    inj_active <= 1'b0;
    rd(12'h050, 64'h4800_0000);
    wr(12'h050, 64'h4800_0000);
    rd(12'h050, 64'h0);
    // Cold reset state and record map
    rd(12'h010, 64'h0);
    rd(12'h090, 64'h0);
    ev(2'b01, 1'b1, 1'b1, 1'b0);
    rd(12'h010, 64'hF000_0000);
    rd(12'h050, 64'h0);
    ev(2'b01, 1'b0, 1'b1, 1'b0);
    wr(12'h010, 64'hFFFF_FFFF_0007_0000);
    rd(12'h010, 64'hF800_0000);
    repeat (2) @(posedge ref_clk);
    #1 chk(selected_status_64, 64'hF800_0000);
    chk({32'h0, selected_status_32}, 64'hF800_0000);
    // Clear valid only through the system view
    @(posedge ref_clk);
    sys_wr <= 1'b1; sys_wdata <= 64'h4000_0000;
    @(posedge ref_clk);
    sys_wr <= 1'b0;
    rd(12'h010, 64'h8000_0000);
    wr(12'h010, 64'hB800_0000);
    rd(12'h010, 64'h0);
    // Stale uncorrected state would show on the next plain error
    ev(2'b01, 1'b0, 1'b0, 1'b0);
    rd(12'h010, 64'h4000_0000);
    chk(fault_irq, 1'b0);
    wr(12'h808, 64'h1);
    rd(12'h808, 64'h1);
    chk(fault_irq, 1'b1);
    wr(12'h010, 64'h4000_0000);
    rd(12'h010, 64'h0);
    chk(fault_irq, 1'b0);
    // Deferred event without abort, then set against clear
    write_abort_enable <= 1'b0;
    ev(2'b10, 1'b0, 1'b0, 1'b1);
    rd(12'h050, 64'h4080_0000);
    @(posedge ref_clk);
    reg_wr <= 1'b1; reg_addr <= 12'h050; reg_wdata <= 64'h4000_0000;
    err_event <= 2'b10; err_uncorr <= 1'b1; err_deferred <= 1'b0;
    @(posedge ref_clk);
    reg_wr <= 1'b0; err_event <= 2'b00;
    rd(12'h050, 64'h6880_0000);
    record_index_select <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 chk(selected_status_64, 64'h6880_0000);
    chk({32'h0, selected_status_32}, 64'h6880_0000);
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    rd(12'h050, 64'h0);
    rd(12'h808, 64'h0);
    finish_test;
  end
endmodule
`default_nettype wire
